// ---- design/memmap_params.svh ----
// address map constants for the region decoder
`ifndef MEMMAP_PARAMS_SVH
`define MEMMAP_PARAMS_SVH

`define MM_ADDR_W        24
`define MM_SPACE_BYTES   32'h0100_0000
`define MM_SPACE_TOP     24'hFFFFFF
`define MM_PERIPH_LO     24'h000000
`define MM_PERIPH_HI     24'h0003FF
`define MM_PERIPH_OFF_W  10
`define MM_RAM_LO        24'h000400
`define MM_RAM_SIZE      32'h0000_8000
`define MM_ROM_SIZE      32'h0004_0000
`define MM_FIXVEC_LO     24'hFFFFDC
`define MM_SPVEC_LO      24'hFFFE00
`define MM_SPVEC_HI      24'hFFFFDB
`define MM_BLK_LSB       4
`define MM_BLK_MSB       9
`define MM_PERIPH_BLOCKS 64
`define MM_PERIPH_MAP    64'hFFFF_FFFF_FFFF_FFFF

`endif

// ---- design/memmap_pkg.sv ----
// types shared by the region decoder files
package memmap_pkg;

  typedef logic [23:0] addr_t;

  // one-hot region code, exactly one bit per decoded address
  typedef enum logic [3:0] {
    REGION_NONE   = 4'h1,
    REGION_PERIPH = 4'h2,
    REGION_RAM    = 4'h4,
    REGION_ROM    = 4'h8
  } region_e;

  typedef enum logic [1:0] {
    ACC_DATA   = 2'h0,
    ACC_STACK  = 2'h1,
    ACC_VECTOR = 2'h2,
    ACC_FETCH  = 2'h3
  } access_e;

endpackage : memmap_pkg

// ---- design/range_if.sv ----
// carrier between the decoder and one range comparator
`timescale 1ns/1ps

interface range_if;
  memmap_pkg::addr_t addr;
  logic              hit;

  modport matcher (input addr, output hit);
  modport user    (output addr, input hit);
endinterface : range_if

// ---- design/range_match.sv ----
// inclusive address range comparator
`timescale 1ns/1ps

module range_match #(
  parameter memmap_pkg::addr_t LO = '0,
  parameter memmap_pkg::addr_t HI = '1
) (
  range_if.matcher m
);

  assign m.hit = (m.addr >= LO) && (m.addr <= HI);

endmodule : range_match

// ---- design/memory_map_address_decoder.sv ----
// registered region decoder for the flat 24-bit address space
// How it works
// - the whole 24-bit space 000000h..FFFFFFh is decoded, every address gets an answer.
// - ROM sits at the top; its size sets its base, 256K gives FC0000h.
// - FFFFDCh to the top is flagged as the fixed interrupt vector area.
// - RAM starts at 000400h; its size sets its end, 32K ends at 0083FFh.
// - 000000h..0003FFh selects the peripheral control register area.
// - unpopulated peripheral addresses are reserved; a hit raises reserved_hit_q and unmapped_q, nothing is selected.
// - FFFE00h..FFFFDBh is flagged as the special page vector table.
// - RAM holds both data and stack; stack writes into RAM are flagged.
`timescale 1ns/1ps
`include "memmap_params.svh"

module memory_map_address_decoder #(
  parameter logic [31:0]                      RAM_SIZE   = `MM_RAM_SIZE,
  parameter logic [31:0]                      ROM_SIZE   = `MM_ROM_SIZE,
  parameter logic [`MM_PERIPH_BLOCKS-1:0]     PERIPH_MAP = `MM_PERIPH_MAP
) (
  // clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           rstn,
  // address request from the bus masters
  input  wire logic                           addr_valid,
  input  wire memmap_pkg::addr_t              addr,
  input  wire logic                           is_write,
  input  wire memmap_pkg::access_e            access_kind,
  // decoded answer, one cycle after the request
  output memmap_pkg::region_e                 region_q,
  output logic                                dec_valid_q,
  output logic                                periph_sel_q,
  output logic                                ram_sel_q,
  output logic                                rom_sel_q,
  output logic                                unmapped_q,
  output logic                                reserved_hit_q,
  output logic                                fixed_vec_q,
  output logic                                special_vec_q,
  output logic                                ram_stack_wr_q,
  output logic [`MM_PERIPH_OFF_W-1:0]         periph_offset_q
);

  ////////////////////////////////////////////////////////////////////////////
  // region bounds from the memory sizes
  localparam memmap_pkg::addr_t ROM_LO = 24'(`MM_SPACE_BYTES - ROM_SIZE);
  localparam memmap_pkg::addr_t RAM_HI = 24'(32'(`MM_RAM_LO) + RAM_SIZE - 32'h1);

  ////////////////////////////////////////////////////////////////////////////
  // range comparators
  range_if periph_r ();
  range_if ram_r ();
  range_if rom_r ();
  range_if fixvec_r ();
  range_if spvec_r ();

  assign periph_r.addr = addr;
  assign ram_r.addr    = addr;
  assign rom_r.addr    = addr;
  assign fixvec_r.addr = addr;
  assign spvec_r.addr  = addr;

  range_match #(.LO(`MM_PERIPH_LO), .HI(`MM_PERIPH_HI)) u_periph (.m(periph_r));
  range_match #(.LO(`MM_RAM_LO),    .HI(RAM_HI))        u_ram    (.m(ram_r));
  range_match #(.LO(ROM_LO),        .HI(`MM_SPACE_TOP)) u_rom    (.m(rom_r));
  range_match #(.LO(`MM_FIXVEC_LO), .HI(`MM_SPACE_TOP)) u_fixvec (.m(fixvec_r));
  range_match #(.LO(`MM_SPVEC_LO),  .HI(`MM_SPVEC_HI))  u_spvec  (.m(spvec_r));

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire logic [`MM_BLK_MSB-`MM_BLK_LSB:0] blk_idx;
  wire logic                             blk_pop;
  wire logic                             periph_ok;
  wire logic                             periph_resv;
  wire logic                             ram_ok;
  wire logic                             rom_ok;
  wire logic                             stack_wr;
  wire memmap_pkg::region_e              region_d;

  assign blk_idx     = addr[`MM_BLK_MSB:`MM_BLK_LSB];
  assign blk_pop     = PERIPH_MAP[blk_idx];
  assign periph_ok   = periph_r.hit && blk_pop;
  assign periph_resv = periph_r.hit && !blk_pop;
  assign ram_ok      = ram_r.hit && !periph_r.hit;
  assign rom_ok      = rom_r.hit && !ram_ok && !periph_r.hit;
  assign stack_wr    = ram_ok && is_write && (access_kind == memmap_pkg::ACC_STACK);

  // priority chain keeps the code one-hot even with odd sizes
  assign region_d = periph_ok ? memmap_pkg::REGION_PERIPH :
                    ram_ok    ? memmap_pkg::REGION_RAM    :
                    rom_ok    ? memmap_pkg::REGION_ROM    :
                                memmap_pkg::REGION_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // answer registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      region_q        <= memmap_pkg::REGION_NONE;
      dec_valid_q     <= 1'b0;
      periph_offset_q <= '0;
    end else begin
      region_q        <= addr_valid ? region_d : memmap_pkg::REGION_NONE;
      dec_valid_q     <= addr_valid;
      periph_offset_q <= (addr_valid && periph_ok) ? addr[`MM_PERIPH_OFF_W-1:0] : '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      periph_sel_q   <= 1'b0;
      ram_sel_q      <= 1'b0;
      rom_sel_q      <= 1'b0;
      unmapped_q     <= 1'b0;
    end else begin
      periph_sel_q   <= addr_valid && periph_ok;
      ram_sel_q      <= addr_valid && ram_ok;
      rom_sel_q      <= addr_valid && rom_ok;
      unmapped_q     <= addr_valid && (region_d == memmap_pkg::REGION_NONE);
    end
  end

  // vector areas are attributes of a ROM hit, not regions of their own
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reserved_hit_q <= 1'b0;
      fixed_vec_q    <= 1'b0;
      special_vec_q  <= 1'b0;
      ram_stack_wr_q <= 1'b0;
    end else begin
      reserved_hit_q <= addr_valid && periph_resv;
      fixed_vec_q    <= addr_valid && rom_ok && fixvec_r.hit;
      special_vec_q  <= addr_valid && rom_ok && spvec_r.hit;
      ram_stack_wr_q <= addr_valid && stack_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  region_onehot_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    dec_valid_q |-> $onehot({periph_sel_q, ram_sel_q, rom_sel_q, unmapped_q})
      && (region_q == memmap_pkg::REGION_NONE) == unmapped_q)
    else $error("region selects not one-hot");

  periph_range_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    addr_valid && (addr <= `MM_PERIPH_HI) && PERIPH_MAP[addr[`MM_BLK_MSB:`MM_BLK_LSB]]
      |=> periph_sel_q && (periph_offset_q == $past(addr[`MM_PERIPH_OFF_W-1:0])))
    else $error("peripheral address not selected");

  periph_reserved_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    reserved_hit_q |-> !periph_sel_q && unmapped_q && ($past(addr) <= `MM_PERIPH_HI))
    else $error("reserved peripheral address selected a register");

  ram_range_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ram_sel_q |-> ($past(addr) >= `MM_RAM_LO) && ($past(addr) <= RAM_HI)
      && (region_q == memmap_pkg::REGION_RAM))
    else $error("ram select outside ram window");

  rom_top_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    addr_valid && (addr >= ROM_LO) ##1 dec_valid_q |-> rom_sel_q)
    else $error("top-aligned rom address not selected");

  fixed_vec_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    addr_valid |=> fixed_vec_q == ($past(addr) >= `MM_FIXVEC_LO))
    else $error("fixed vector flag wrong");

  special_vec_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    special_vec_q |-> rom_sel_q && !fixed_vec_q
      && ($past(addr) >= `MM_SPVEC_LO) && ($past(addr) <= `MM_SPVEC_HI))
    else $error("special page flag wrong");

  stack_wr_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ram_stack_wr_q |-> ram_sel_q && $past(is_write)
      && ($past(access_kind) == memmap_pkg::ACC_STACK))
    else $error("stack write flag without ram stack write");

  idle_quiet_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !addr_valid |=> !dec_valid_q && !periph_sel_q && !ram_sel_q && !rom_sel_q && !unmapped_q)
    else $error("select asserted without a request");

  valid_follows_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    addr_valid |=> dec_valid_q)
    else $error("request without a decoded answer");

  sel_region_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    dec_valid_q |-> ((region_q == memmap_pkg::REGION_PERIPH) == periph_sel_q)
      && ((region_q == memmap_pkg::REGION_RAM) == ram_sel_q)
      && ((region_q == memmap_pkg::REGION_ROM) == rom_sel_q))
    else $error("region code disagrees with the selects");

  hole_unmapped_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    addr_valid && (addr > RAM_HI) && (addr < ROM_LO)
      |=> unmapped_q && !ram_sel_q && !rom_sel_q && !periph_sel_q)
    else $error("hole between ram and rom selected a region");

  ram_cover_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    addr_valid && (addr >= `MM_RAM_LO) && (addr <= RAM_HI)
      |=> ram_sel_q && (region_q == memmap_pkg::REGION_RAM))
    else $error("ram address not selected");

  stack_seen_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    addr_valid && is_write && (access_kind == memmap_pkg::ACC_STACK)
      && (addr >= `MM_RAM_LO) && (addr <= RAM_HI)
      |=> ram_stack_wr_q)
    else $error("stack write into ram not flagged");

  reserved_seen_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    addr_valid && (addr <= `MM_PERIPH_HI) && !PERIPH_MAP[addr[`MM_BLK_MSB:`MM_BLK_LSB]]
      |=> reserved_hit_q && !periph_sel_q && (periph_offset_q == '0))
    else $error("reserved peripheral block not flagged");

  offset_idle_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !periph_sel_q |-> (periph_offset_q == '0))
    else $error("peripheral offset without a peripheral hit");

  vec_exclusive_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    fixed_vec_q || special_vec_q |-> rom_sel_q && !(fixed_vec_q && special_vec_q))
    else $error("vector flags overlap or lack a rom hit");

  special_cover_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    addr_valid && (addr >= ROM_LO) && (addr >= `MM_SPVEC_LO) && (addr <= `MM_SPVEC_HI)
      |=> special_vec_q && rom_sel_q)
    else $error("special page vector address not flagged");

endmodule : memory_map_address_decoder

// ---- tb/bus_master_model.sv ----
// bus master model issuing address requests to the decoder
`timescale 1ns/1ps

module bus_master_model (
  // clock
  input  wire logic           ref_clk,
  // request
  output memmap_pkg::addr_t   addr,
  output logic                addr_valid,
  output logic                is_write,
  output memmap_pkg::access_e access_kind
);
  initial begin
    addr_valid = 1'b0;
    addr = 24'h000000;
    is_write = 1'b0;
    access_kind = memmap_pkg::ACC_DATA;
  end

  task automatic issue(input memmap_pkg::addr_t a, input logic w, input memmap_pkg::access_e k);
    @(posedge ref_clk);
    addr_valid <= 1'b1;
    addr <= a;
    is_write <= w;
    access_kind <= k;
  endtask : issue

  // released addr and is_write lines never keep the old value; access_kind keeps it
  task automatic idle();
    @(posedge ref_clk);
    addr_valid <= 1'b0;
    addr <= ~addr;
    is_write <= ~is_write;
  endtask : idle
endmodule : bus_master_model

// ---- tb/memory_map_address_decoder_tb_top.sv ----
// scoreboard bench for the region decoder
`timescale 1ns/1ps

module memory_map_address_decoder_tb_top;
  localparam logic [63:0] MAP = 64'hFFFF_FFFF_FFFF_FFF7;
  logic                ref_clk;
  logic                rstn;
  logic                addr_valid;
  logic                is_write;
  memmap_pkg::addr_t   addr;
  memmap_pkg::access_e access_kind;
  memmap_pkg::region_e region_q;
  wire logic [7:0]     flags;
  logic                dec_valid_q;
  logic [9:0]          periph_offset_q;
  logic [21:0]         exp_q[$];
  logic [31:0]         seed;
  int                  miscompares;
  int                  total_checks;

  bus_master_model bus_master_model_inst (.ref_clk(ref_clk), .addr(addr), .addr_valid(addr_valid),
    .is_write(is_write), .access_kind(access_kind));

  memory_map_address_decoder #(.PERIPH_MAP(MAP)) memory_map_address_decoder_inst (.ref_clk(ref_clk),
    .rstn(rstn), .addr_valid(addr_valid), .addr(addr), .is_write(is_write), .access_kind(access_kind),
    .region_q(region_q), .dec_valid_q(dec_valid_q), .periph_sel_q(flags[7]), .ram_sel_q(flags[6]),
    .rom_sel_q(flags[5]), .unmapped_q(flags[4]), .reserved_hit_q(flags[3]), .fixed_vec_q(flags[2]),
    .special_vec_q(flags[1]), .ram_stack_wr_q(flags[0]), .periph_offset_q(periph_offset_q));

  function automatic logic [21:0] expect_of(memmap_pkg::addr_t a, logic w, memmap_pkg::access_e k);
    logic p, r, o, s;
    s = a <= 24'h0003FF;
    p = s && MAP[a[9:4]];
    r = (a >= 24'h000400) && (a <= 24'h0083FF);
    o = a >= 24'hFC0000;
    return {p ? 4'h2 : r ? 4'h4 : o ? 4'h8 : 4'h1, p, r, o, !(p || r || o), s && !p, o && a >= 24'hFFFFDC,
      o && a >= 24'hFFFE00 && a <= 24'hFFFFDB, r && w && k == memmap_pkg::ACC_STACK, p ? a[9:0] : 10'h000};
  endfunction : expect_of

  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic check(string n, logic [21:0] e, logic [21:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic send(memmap_pkg::addr_t a, logic w, memmap_pkg::access_e k);
    bus_master_model_inst.issue(a, w, k);
    exp_q.push_back(expect_of(a, w, k));
  endtask : send

  task automatic report_and_stop();
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(negedge ref_clk) begin
    if (rstn === 1'b1) begin
      if (dec_valid_q === 1'b1) begin
        if (exp_q.size() == 0) check("extra answer", 22'h0, 22'h1);
        else check("decode", exp_q.pop_front(), {region_q, flags, periph_offset_q});
      end
      else check("idle", 22'h040000, {region_q, flags, periph_offset_q});
    end
  end

  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    rstn = 1'b0;
    seed = 32'hBD75;
    miscompares = 0;
    total_checks = 0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    send(24'h000000, 1'b0, memmap_pkg::ACC_DATA);
    send(24'h0003FF, 1'b1, memmap_pkg::ACC_DATA);
    send(24'h000034, 1'b0, memmap_pkg::ACC_DATA);
    send(24'h000400, 1'b1, memmap_pkg::ACC_STACK);
    send(24'h0083FF, 1'b0, memmap_pkg::ACC_STACK);
    send(24'h008400, 1'b1, memmap_pkg::ACC_STACK);
    send(24'hFBFFFF, 1'b0, memmap_pkg::ACC_FETCH);
    send(24'hFC0000, 1'b0, memmap_pkg::ACC_FETCH);
    send(24'hFFFDFF, 1'b0, memmap_pkg::ACC_VECTOR);
    send(24'hFFFE00, 1'b0, memmap_pkg::ACC_VECTOR);
    send(24'hFFFFDB, 1'b0, memmap_pkg::ACC_VECTOR);
    send(24'hFFFFDC, 1'b0, memmap_pkg::ACC_VECTOR);
    send(24'hFFFFFF, 1'b0, memmap_pkg::ACC_VECTOR);
    for (int k = 0; k < 4; k++) send(24'h000405, 1'b1, memmap_pkg::access_e'(k));
    bus_master_model_inst.idle();
    for (int i = 0; i < 400; i++) begin
      seed = xs(seed);
      if (seed[3]) bus_master_model_inst.idle();
      else send(seed[31:30] == 2'h0 ? {14'h0, seed[13:4]} : seed[31:30] == 2'h1 ? 24'h0083F0 + seed[13:4]
        : seed[31:30] == 2'h2 ? {8'hFF, seed[19:4]} : seed[27:4], seed[2], memmap_pkg::access_e'(seed[1:0]));
    end
    repeat (3) bus_master_model_inst.idle();
    check("pending", 22'h0, 22'(exp_q.size()));
    report_and_stop();
  end
endmodule : memory_map_address_decoder_tb_top
